/* File: logic/ecnt_params.svh */
`ifndef ECNT_PARAMS_SVH
`define ECNT_PARAMS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ECNT_ADDR_PORT3_DIR 16'hff23
`define ECNT_ADDR_ISC 16'hff4f
`define ECNT_ADDR_CLKSEL0 16'hff6a
`define ECNT_ADDR_MODE0 16'hff6b
`define ECNT_ADDR_CLKSEL1 16'hff8c
`define ECNT_ADDR_MODE1 16'hff43
`define ECNT_ADDR_CLKSEL2 16'hff5b
`define ECNT_ADDR_MODE2 16'hff5c
`define ECNT_ADDR_CMP0 16'hff70
`define ECNT_ADDR_CNT0 16'hff71
`define ECNT_ADDR_CMP1 16'hff72
`define ECNT_ADDR_CNT1 16'hff73
`define ECNT_ADDR_CMP2 16'hff74
`define ECNT_ADDR_CNT2 16'hff75
`define ECNT_ADDR_CASC_CTRL 16'hff76
`define ECNT_ADDR_UPPER_LO 16'hff77
`define ECNT_ADDR_UPPER_HI 16'hff78

// ----------------------------------------------------------------
// Field positions, masks and reset values
// ----------------------------------------------------------------
`define ECNT_BIT_COUNT_EN 7
`define ECNT_BIT_CASC_EN 7
`define ECNT_CLKSEL_MSB 2
`define ECNT_ISC_MSB 5
`define ECNT_P3_DIR_LSB 1
`define ECNT_P3_DIR_MSB 4
`define ECNT_RST_PORT3_DIR 8'hff
`define ECNT_RST_ZERO 8'h00
`define ECNT_RST_UPPER 16'h0000
`define ECNT_PORT3_FIXED_ONES 8'he1
`define ECNT_PORT3_IMPL_MASK 8'h1e
`define ECNT_ONE_BYTE 8'h01
`define ECNT_ONE_WORD 16'h0001

// ----------------------------------------------------------------
// Count clock and serial pin selection codes
// ----------------------------------------------------------------
`define ECNT_SEL_EDGE_FALL 3'h0
`define ECNT_SEL_EDGE_RISE 3'h1
`define ECNT_SEL_2 3'h2
`define ECNT_SEL_3 3'h3
`define ECNT_SEL_4 3'h4
`define ECNT_SEL_5 3'h5
`define ECNT_SEL_6 3'h6
`define ECNT_SEL_7 3'h7
`define ECNT_SERSEL_LO 2'h0
`define ECNT_SERSEL_HI 2'h2

// ----------------------------------------------------------------
// Prescaler taps, as powers of two of the peripheral clock
// ----------------------------------------------------------------
`define ECNT_PRESC_W 13
`define ECNT_DIV_P0 0
`define ECNT_DIV_P1 1
`define ECNT_DIV_P2 2
`define ECNT_DIV_P4 4
`define ECNT_DIV_P6 6
`define ECNT_DIV_P8 8
`define ECNT_DIV_P12 12
`define ECNT_DIV_P13 13

`endif

/* File: logic/ecnt_pkg.sv */
package ecnt_pkg;

  // Per-counter configuration as software leaves it
  typedef struct packed {
    logic count_enable_bit;
    logic [2:0] clock_select_reg;
    logic [7:0] compare_value_reg;
  } ecnt_chan_cfg_t;

  // Input switch fields, bit 5 down to bit 0
  typedef struct packed {
    logic serial_pin_select_hi;
    logic serial_pin_select_lo;
    logic serial_rx_input_enable;
    logic event_gate_select;
    logic capture_src_select;
    logic irq0_src_select;
  } ecnt_isc_t;

  typedef enum logic [1:0] {
    UP_IDLE,
    UP_ARMED,
    UP_RUN
  } ecnt_up_state_t;

endpackage

/* File: logic/ecnt_prescaler.sv */
`timescale 1ns/10ps
`include "ecnt_params.svh"

module ecnt_prescaler
(
  input wire logic clk,
  input wire logic srst,
  output logic [`ECNT_PRESC_W:0] div_tick
);

  logic [`ECNT_PRESC_W-1:0] presc;
  logic [`ECNT_PRESC_W-1:0] next_presc;

  // ----------------------------------------------------------------
  // Free-running divider
  // ----------------------------------------------------------------
  // Never stopped, so a counter start lands anywhere in a count clock period
  always_comb
  begin
    next_presc = presc + {{(`ECNT_PRESC_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      presc <= '0;
    end
    else
    begin
      presc <= next_presc;
    end
  end

  assign div_tick[0] = 1'b1;

  // Tap k pulses once every 2^k clocks
  genvar k;
  generate
    for (k = 1; k <= `ECNT_PRESC_W; k++)
    begin : g_tap
      assign div_tick[k] = &presc[k-1:0];
    end
  endgenerate

endmodule

/* File: logic/ecnt_channel.sv */
`timescale 1ns/10ps
`include "ecnt_params.svh"

module ecnt_channel
(
  input wire logic clk,
  input wire logic srst,
  input ecnt_pkg::ecnt_chan_cfg_t cfg,
  input wire logic tick,
  output logic [7:0] count_register,
  output logic match_pulse
);

  logic [7:0] next_count;
  logic next_match;

  // ----------------------------------------------------------------
  // Count and compare
  // ----------------------------------------------------------------
  always_comb
  begin
    next_count = count_register;
    next_match = 1'b0;
    if (!cfg.count_enable_bit)
    begin
      next_count = `ECNT_RST_ZERO;
    end
    else if (tick)
    begin
      if (count_register == cfg.compare_value_reg)
      begin
        next_count = `ECNT_RST_ZERO;
        next_match = 1'b1;
      end
      else
      begin
        next_count = count_register + `ECNT_ONE_BYTE;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count_register <= `ECNT_RST_ZERO;
      match_pulse <= 1'b0;
    end
    else
    begin
      count_register <= next_count;
      match_pulse <= next_match;
    end
  end

endmodule

/* File: logic/ecnt_top.sv */
`timescale 1ns/10ps
`include "ecnt_params.svh"

module ecnt_top
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic EVENT_INPUT_PIN,
  input wire logic GATING_TIMER_OUTPUT,
  input wire logic TIMER_H1_OUTPUT,
  input wire logic CAPTURE_PIN,
  input wire logic EXT_IRQ0_PIN,
  input wire logic SERIAL_PIN_LO,
  input wire logic SERIAL_PIN_HI,
  output logic [2:0] MATCH_INTERRUPT,
  output logic CAPTURE_INPUT,
  output logic EXTERNAL_IRQ0_INPUT,
  output logic SERIAL_RECEIVE_INPUT,
  output logic [3:0] PORT3_OE
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  ecnt_pkg::ecnt_chan_cfg_t cfg [3];
  ecnt_pkg::ecnt_chan_cfg_t next_cfg [3];
  ecnt_pkg::ecnt_isc_t input_source_select;
  ecnt_pkg::ecnt_isc_t next_isc;
  logic [7:0] port3_direction;
  logic [7:0] next_port3_direction;
  logic casc_enable;
  logic next_casc_enable;
  logic [7:0] next_rdata;

  logic [7:0] count_register [3];
  logic [2:0] match;
  logic [2:0] tick;
  logic [`ECNT_PRESC_W:0] div_tick;

  logic event_gated;
  logic event_prev;
  logic next_event_prev;
  logic h1_prev;
  logic next_h1_prev;
  logic event_rise;
  logic event_fall;
  logic h1_rise;

  ecnt_pkg::ecnt_up_state_t up_state;
  ecnt_pkg::ecnt_up_state_t next_up_state;
  logic [15:0] upper_16bit_counter;
  logic [15:0] next_upper;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Writes land whenever they come; a compare rewritten mid-run takes effect
  // at once and may skip a match, so software stops the counter first
  always_comb
  begin
    next_cfg = cfg;
    next_isc = input_source_select;
    next_port3_direction = port3_direction;
    next_casc_enable = casc_enable;
    if (WR)
    begin
      case (ADDR)
        `ECNT_ADDR_CLKSEL0: next_cfg[0].clock_select_reg = WDATA[`ECNT_CLKSEL_MSB:0];
        `ECNT_ADDR_CLKSEL1: next_cfg[1].clock_select_reg = WDATA[`ECNT_CLKSEL_MSB:0];
        `ECNT_ADDR_CLKSEL2: next_cfg[2].clock_select_reg = WDATA[`ECNT_CLKSEL_MSB:0];
        `ECNT_ADDR_MODE0: next_cfg[0].count_enable_bit = WDATA[`ECNT_BIT_COUNT_EN];
        `ECNT_ADDR_MODE1: next_cfg[1].count_enable_bit = WDATA[`ECNT_BIT_COUNT_EN];
        `ECNT_ADDR_MODE2: next_cfg[2].count_enable_bit = WDATA[`ECNT_BIT_COUNT_EN];
        `ECNT_ADDR_CMP0: next_cfg[0].compare_value_reg = WDATA;
        `ECNT_ADDR_CMP1: next_cfg[1].compare_value_reg = WDATA;
        `ECNT_ADDR_CMP2: next_cfg[2].compare_value_reg = WDATA;
        `ECNT_ADDR_ISC: next_isc = WDATA[`ECNT_ISC_MSB:0];
        `ECNT_ADDR_PORT3_DIR: next_port3_direction = WDATA | `ECNT_PORT3_FIXED_ONES;
        `ECNT_ADDR_CASC_CTRL: next_casc_enable = WDATA[`ECNT_BIT_CASC_EN];
        default: next_casc_enable = casc_enable;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Read data is registered, so it appears the clock after RD
  always_comb
  begin
    next_rdata = RDATA;
    if (RD)
    begin
      next_rdata = `ECNT_RST_ZERO;
      case (ADDR)
        `ECNT_ADDR_CLKSEL0: next_rdata[`ECNT_CLKSEL_MSB:0] = cfg[0].clock_select_reg;
        `ECNT_ADDR_CLKSEL1: next_rdata[`ECNT_CLKSEL_MSB:0] = cfg[1].clock_select_reg;
        `ECNT_ADDR_CLKSEL2: next_rdata[`ECNT_CLKSEL_MSB:0] = cfg[2].clock_select_reg;
        `ECNT_ADDR_MODE0: next_rdata[`ECNT_BIT_COUNT_EN] = cfg[0].count_enable_bit;
        `ECNT_ADDR_MODE1: next_rdata[`ECNT_BIT_COUNT_EN] = cfg[1].count_enable_bit;
        `ECNT_ADDR_MODE2: next_rdata[`ECNT_BIT_COUNT_EN] = cfg[2].count_enable_bit;
        `ECNT_ADDR_CMP0: next_rdata = cfg[0].compare_value_reg;
        `ECNT_ADDR_CMP1: next_rdata = cfg[1].compare_value_reg;
        `ECNT_ADDR_CMP2: next_rdata = cfg[2].compare_value_reg;
        `ECNT_ADDR_CNT0: next_rdata = count_register[0];
        `ECNT_ADDR_CNT1: next_rdata = count_register[1];
        `ECNT_ADDR_CNT2: next_rdata = count_register[2];
        `ECNT_ADDR_ISC: next_rdata[`ECNT_ISC_MSB:0] = input_source_select;
        `ECNT_ADDR_PORT3_DIR: next_rdata = port3_direction | `ECNT_PORT3_FIXED_ONES;
        `ECNT_ADDR_CASC_CTRL: next_rdata[`ECNT_BIT_CASC_EN] = casc_enable;
        `ECNT_ADDR_UPPER_LO: next_rdata = upper_16bit_counter[7:0];
        `ECNT_ADDR_UPPER_HI: next_rdata = upper_16bit_counter[15:8];
        default: next_rdata = `ECNT_RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      for (int i = 0; i < 3; i++)
      begin
        cfg[i] <= '0;
      end
      input_source_select <= '0;
      port3_direction <= `ECNT_RST_PORT3_DIR;
      casc_enable <= 1'b0;
      RDATA <= `ECNT_RST_ZERO;
    end
    else
    begin
      cfg <= next_cfg;
      input_source_select <= next_isc;
      port3_direction <= next_port3_direction;
      casc_enable <= next_casc_enable;
      RDATA <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Input switching
  // ----------------------------------------------------------------
  // Gating with a low level can itself make a falling edge; users of
  // falling-edge counting with the gate on must allow for it
  assign event_gated = input_source_select.event_gate_select ?
    (EVENT_INPUT_PIN & GATING_TIMER_OUTPUT) : EVENT_INPUT_PIN;

  always_comb
  begin
    unique case ({input_source_select.serial_pin_select_hi, input_source_select.serial_pin_select_lo})
      `ECNT_SERSEL_HI: SERIAL_RECEIVE_INPUT = SERIAL_PIN_HI;
      `ECNT_SERSEL_LO: SERIAL_RECEIVE_INPUT = SERIAL_PIN_LO & input_source_select.serial_rx_input_enable;
      default: SERIAL_RECEIVE_INPUT = 1'b0;
    endcase
  end

  assign CAPTURE_INPUT = input_source_select.capture_src_select ? SERIAL_RECEIVE_INPUT : CAPTURE_PIN;
  assign EXTERNAL_IRQ0_INPUT = input_source_select.irq0_src_select ? SERIAL_RECEIVE_INPUT : EXT_IRQ0_PIN;

  // Direction 0 means output buffer on
  assign PORT3_OE = ~port3_direction[`ECNT_P3_DIR_MSB:`ECNT_P3_DIR_LSB];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  always_comb
  begin
    next_event_prev = event_gated;
    next_h1_prev = TIMER_H1_OUTPUT;
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      event_prev <= 1'b0;
      h1_prev <= 1'b0;
    end
    else
    begin
      event_prev <= next_event_prev;
      h1_prev <= next_h1_prev;
    end
  end

  assign event_rise = event_gated & ~event_prev;
  assign event_fall = ~event_gated & event_prev;
  assign h1_rise = TIMER_H1_OUTPUT & ~h1_prev;

  // ----------------------------------------------------------------
  // Count clock selection
  // ----------------------------------------------------------------
  ecnt_prescaler u_presc
  (
    .clk(MCLK),
    .srst(SRST),
    .div_tick(div_tick)
  );

  // Taps are shared and free-running, hence a start error of up to one
  // count clock period
  always_comb
  begin
    case (cfg[0].clock_select_reg)
      `ECNT_SEL_2: tick[0] = div_tick[`ECNT_DIV_P0];
      `ECNT_SEL_3: tick[0] = div_tick[`ECNT_DIV_P1];
      `ECNT_SEL_4: tick[0] = div_tick[`ECNT_DIV_P2];
      `ECNT_SEL_5: tick[0] = div_tick[`ECNT_DIV_P6];
      `ECNT_SEL_6: tick[0] = div_tick[`ECNT_DIV_P8];
      `ECNT_SEL_7: tick[0] = div_tick[`ECNT_DIV_P13];
      default: tick[0] = 1'b0;
    endcase
    case (cfg[1].clock_select_reg)
      `ECNT_SEL_2: tick[1] = div_tick[`ECNT_DIV_P0];
      `ECNT_SEL_3: tick[1] = div_tick[`ECNT_DIV_P1];
      `ECNT_SEL_4: tick[1] = div_tick[`ECNT_DIV_P4];
      `ECNT_SEL_5: tick[1] = div_tick[`ECNT_DIV_P6];
      `ECNT_SEL_6: tick[1] = div_tick[`ECNT_DIV_P8];
      `ECNT_SEL_7: tick[1] = h1_rise;
      default: tick[1] = 1'b0;
    endcase
    case (cfg[2].clock_select_reg)
      `ECNT_SEL_EDGE_FALL: tick[2] = event_fall;
      `ECNT_SEL_EDGE_RISE: tick[2] = event_rise;
      `ECNT_SEL_2: tick[2] = div_tick[`ECNT_DIV_P0];
      `ECNT_SEL_3: tick[2] = div_tick[`ECNT_DIV_P1];
      `ECNT_SEL_4: tick[2] = div_tick[`ECNT_DIV_P4];
      `ECNT_SEL_5: tick[2] = div_tick[`ECNT_DIV_P6];
      `ECNT_SEL_6: tick[2] = div_tick[`ECNT_DIV_P8];
      default: tick[2] = div_tick[`ECNT_DIV_P12];
    endcase
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Each channel matches on the tick that finds count equal to compare,
  // giving compare plus one ticks between interrupts
  genvar n;
  generate
    for (n = 0; n < 3; n++)
    begin : g_chan
      ecnt_channel u_chan
      (
        .clk(MCLK),
        .srst(SRST),
        .cfg(cfg[n]),
        .tick(tick[n]),
        .count_register(count_register[n]),
        .match_pulse(match[n])
      );
    end
  endgenerate

  assign MATCH_INTERRUPT = match;

  // ----------------------------------------------------------------
  // Upper 16-bit cascade counter
  // ----------------------------------------------------------------
  // Counts match pulses of the third counter; the first pulse after start
  // is swallowed by the start synchroniser, wraps are not
  always_comb
  begin
    next_up_state = up_state;
    next_upper = upper_16bit_counter;
    if (!casc_enable)
    begin
      next_up_state = ecnt_pkg::UP_IDLE;
      next_upper = `ECNT_RST_UPPER;
    end
    else
    begin
      unique case (up_state)
        ecnt_pkg::UP_IDLE:
        begin
          next_up_state = ecnt_pkg::UP_ARMED;
        end
        ecnt_pkg::UP_ARMED:
        begin
          if (match[2])
          begin
            next_up_state = ecnt_pkg::UP_RUN;
          end
        end
        ecnt_pkg::UP_RUN:
        begin
          if (match[2])
          begin
            next_upper = upper_16bit_counter + `ECNT_ONE_WORD;
          end
        end
        default: next_up_state = ecnt_pkg::UP_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      up_state <= ecnt_pkg::UP_IDLE;
      upper_16bit_counter <= `ECNT_RST_UPPER;
    end
    else
    begin
      up_state <= next_up_state;
      upper_16bit_counter <= next_upper;
    end
  end

endmodule

/* File: tb/ecnt_checker.sv */
`timescale 1ns/10ps
module ecnt_checker
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic EVENT_INPUT_PIN,
  input wire logic GATING_TIMER_OUTPUT,
  input wire logic TIMER_H1_OUTPUT,
  input wire logic CAPTURE_PIN,
  input wire logic EXT_IRQ0_PIN,
  input wire logic SERIAL_PIN_LO,
  input wire logic SERIAL_PIN_HI,
  input wire logic [2:0] MATCH_INTERRUPT,
  input wire logic CAPTURE_INPUT,
  input wire logic EXTERNAL_IRQ0_INPUT,
  input wire logic SERIAL_RECEIVE_INPUT,
  input wire logic [3:0] PORT3_OE
);
  logic [5:0] input_source_select;
  logic [3:0] dir;
  logic [7:0] cmp0;
  logic [7:0] cmp1;
  logic [2:0] sel0;
  logic en0;
  logic en2;
  logic ok;
  logic [8:0] gap;

  // ----------------------------------------------------------------
  // Shadow of the written configuration
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      input_source_select <= 6'h00;
      dir <= 4'hf;
      cmp0 <= 8'h00;
      cmp1 <= 8'h00;
      sel0 <= 3'h0;
      en0 <= 1'b0;
      en2 <= 1'b0;
      ok <= 1'b0;
      gap <= 9'h000;
    end
    else
    begin
      if (WR && ADDR == 16'hff4f)
        input_source_select <= WDATA[5:0];
      if (WR && ADDR == 16'hff23)
        dir <= WDATA[4:1];
      if (WR && ADDR == 16'hff70)
        cmp0 <= WDATA;
      if (WR && ADDR == 16'hff72)
        cmp1 <= WDATA;
      if (WR && ADDR == 16'hff6a)
        sel0 <= WDATA[2:0];
      if (WR && ADDR == 16'hff6b)
        en0 <= WDATA[7];
      if (WR && ADDR == 16'hff5c)
        en2 <= WDATA[7];
      gap <= MATCH_INTERRUPT[0] ? 9'h001 : gap + {8'h00, gap != 9'h1ff};
      // A gap is trusted only between two matches with no setup write in between
      if (WR && (ADDR == 16'hff70 || ADDR == 16'hff6a || ADDR == 16'hff6b))
        ok <= 1'b0;
      else if (MATCH_INTERRUPT[0])
        ok <= 1'b1;
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);

  a_reset_quiet: assert property (disable iff (1'b0) SRST |=>
    MATCH_INTERRUPT == 3'h0 && PORT3_OE == 4'h0 && RDATA == 8'h00)
    else $error("outputs not idle after reset");
  a_port3_enable: assert property (PORT3_OE == ~dir)
    else $error("port3 enable differs from direction");
  a_capture_route: assert property (
    CAPTURE_INPUT == (input_source_select[1] ? SERIAL_RECEIVE_INPUT : CAPTURE_PIN))
    else $error("capture source wrong");
  a_irq0_route: assert property (
    EXTERNAL_IRQ0_INPUT == (input_source_select[0] ? SERIAL_RECEIVE_INPUT : EXT_IRQ0_PIN))
    else $error("irq0 source wrong");
  a_serial_gate: assert property (SERIAL_RECEIVE_INPUT == (input_source_select[5:4] == 2'h0 ?
    SERIAL_PIN_LO & input_source_select[3] : input_source_select[5:4] == 2'h2 && SERIAL_PIN_HI))
    else $error("serial receive source wrong");
  a_match_gap: assert property (MATCH_INTERRUPT[0] && ok && en0 && sel0 == 3'h2
    |-> gap == {1'b0, cmp0} + 9'h001)
    else $error("match interval wrong");
  a_stop_silent: assert property (!en2 && !$past(en2) |-> !MATCH_INTERRUPT[2])
    else $error("match while stopped");
  a_match_pulse: assert property (MATCH_INTERRUPT[1] && cmp1 != 8'h00
    |=> !MATCH_INTERRUPT[1])
    else $error("match longer than one cycle");
endmodule

bind ecnt_top ecnt_checker chk_u (.MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .EVENT_INPUT_PIN(EVENT_INPUT_PIN),
  .GATING_TIMER_OUTPUT(GATING_TIMER_OUTPUT), .TIMER_H1_OUTPUT(TIMER_H1_OUTPUT),
  .CAPTURE_PIN(CAPTURE_PIN), .EXT_IRQ0_PIN(EXT_IRQ0_PIN), .SERIAL_PIN_LO(SERIAL_PIN_LO),
  .SERIAL_PIN_HI(SERIAL_PIN_HI), .MATCH_INTERRUPT(MATCH_INTERRUPT),
  .CAPTURE_INPUT(CAPTURE_INPUT), .EXTERNAL_IRQ0_INPUT(EXTERNAL_IRQ0_INPUT),
  .SERIAL_RECEIVE_INPUT(SERIAL_RECEIVE_INPUT), .PORT3_OE(PORT3_OE));

/* File: tb/ecnt_event_src.sv */
`timescale 1ns/10ps
module ecnt_event_src
(
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;

  // Whole pulses only, so the line always rests low between bursts
  task automatic burst(input int n, input int w);
    repeat (n)
    begin
      pin = 1'b1;
      repeat (w) @(negedge clk);
      pin = 1'b0;
      repeat (w) @(negedge clk);
    end
  endtask
endmodule

/* File: tb/eight_bit_interval_event_counter_test.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module eight_bit_interval_event_counter_test;
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic [15:0] ADDR = 16'h0000;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] RDATA;
  logic EVENT_INPUT_PIN;
  logic GATING_TIMER_OUTPUT = 1'b0;
  logic TIMER_H1_OUTPUT = 1'b0;
  logic CAPTURE_PIN = 1'b0;
  logic EXT_IRQ0_PIN = 1'b0;
  logic SERIAL_PIN_LO = 1'b0;
  logic SERIAL_PIN_HI = 1'b0;
  logic [2:0] MATCH_INTERRUPT;
  logic CAPTURE_INPUT;
  logic EXTERNAL_IRQ0_INPUT;
  logic SERIAL_RECEIVE_INPUT;
  logic [3:0] PORT3_OE;
  logic s;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_match2 = 0;
  int h1c = 0;
  int m;
  logic [15:0] sel_a [3] = '{16'hff6a, 16'hff8c, 16'hff5b};
  logic [15:0] mode_a [3] = '{16'hff6b, 16'hff43, 16'hff5c};
  logic [15:0] cmp_a [3] = '{16'hff70, 16'hff72, 16'hff74};
  logic [15:0] cnt_a [3] = '{16'hff71, 16'hff73, 16'hff75};
  logic [15:0] zero_a [13] = '{16'hff4f, 16'hff6a, 16'hff6b, 16'hff70, 16'hff71, 16'hff72,
    16'hff73, 16'hff74, 16'hff75, 16'hff76, 16'hff77, 16'hff78, 16'hff00};
  logic [7:0] isc_l [7] = '{8'h00, 8'h03, 8'h08, 8'h0b, 8'h2b, 8'h1b, 8'h30};
  // Code 7 of the second counter follows the H1 stand-in, which rises every 6 cycles
  int divs [3][8] = '{'{0, 0, 1, 2, 4, 64, 256, 8192}, '{0, 0, 1, 2, 16, 64, 256, 6},
    '{0, 0, 1, 2, 16, 64, 256, 4096}};

  ecnt_top dut_u (.MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .EVENT_INPUT_PIN(EVENT_INPUT_PIN), .GATING_TIMER_OUTPUT(GATING_TIMER_OUTPUT),
    .TIMER_H1_OUTPUT(TIMER_H1_OUTPUT), .CAPTURE_PIN(CAPTURE_PIN), .EXT_IRQ0_PIN(EXT_IRQ0_PIN),
    .SERIAL_PIN_LO(SERIAL_PIN_LO), .SERIAL_PIN_HI(SERIAL_PIN_HI),
    .MATCH_INTERRUPT(MATCH_INTERRUPT), .CAPTURE_INPUT(CAPTURE_INPUT),
    .EXTERNAL_IRQ0_INPUT(EXTERNAL_IRQ0_INPUT), .SERIAL_RECEIVE_INPUT(SERIAL_RECEIVE_INPUT),
    .PORT3_OE(PORT3_OE));
  ecnt_event_src ev_u (.clk(MCLK), .pin(EVENT_INPUT_PIN));

  always #10 MCLK = ~MCLK;

  always @(negedge MCLK)
  begin
    h1c = (h1c == 2) ? 0 : h1c + 1;
    if (h1c == 0)
      TIMER_H1_OUTPUT = ~TIMER_H1_OUTPUT;
  end

  // Match pulses are counted at the falling edge, where they have settled
  always @(negedge MCLK)
  begin
    cycles++;
    if (MATCH_INTERRUPT[2] === 1'b1)
      n_match2++;
    if (cycles == 90000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge MCLK);
    ADDR = a;
    WDATA = d;
    WR = 1'b1;
    @(negedge MCLK);
    WR = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge MCLK);
    ADDR = a;
    RD = 1'b1;
    @(negedge MCLK);
    RD = 1'b0;
    `CHK(RDATA, e)
  endtask

  // Setup is done while stopped; the first interval is skipped as start phase is loose
  task automatic gap(input int ch, input int code, input int cmp);
    int n;
    wr(mode_a[ch], 8'h00);
    wr(sel_a[ch], code[7:0]);
    wr(cmp_a[ch], cmp[7:0]);
    wr(mode_a[ch], 8'h80);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      @(negedge MCLK);
      while (MATCH_INTERRUPT[ch] !== 1'b1 && n < 20000)
      begin
        @(negedge MCLK);
        n++;
      end
    end
    `CHK(n + 1, (cmp + 1) * divs[ch][code])
    wr(mode_a[ch], 8'h00);
    rd(cnt_a[ch], 8'h00);
  endtask

  task automatic end_of_test();
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(negedge MCLK);
    SRST = 1'b0;
    rd(16'hff23, 8'hff);
    for (int i = 0; i < 13; i++)
      rd(zero_a[i], 8'h00);
    `CHK(PORT3_OE, 4'h0)
    wr(16'hff23, 8'h0a);
    rd(16'hff23, 8'heb);
    `CHK(PORT3_OE, 4'ha)
    wr(16'hff23, 8'hff);
    `CHK(PORT3_OE, 4'h0)
    for (int i = 0; i < 7; i++)
    begin
      wr(16'hff4f, isc_l[i]);
      for (int p = 0; p < 16; p++)
      begin
        @(negedge MCLK);
        {SERIAL_PIN_HI, SERIAL_PIN_LO, CAPTURE_PIN, EXT_IRQ0_PIN} = p[3:0];
        #1;
        s = (isc_l[i][5:4] == 2'h0) ? (p[2] & isc_l[i][3]) : (isc_l[i][5:4] == 2'h2 && p[3]);
        `CHK(SERIAL_RECEIVE_INPUT, s)
        `CHK(CAPTURE_INPUT, isc_l[i][1] ? s : p[1])
        `CHK(EXTERNAL_IRQ0_INPUT, isc_l[i][0] ? s : p[0])
      end
    end
    wr(16'hff4f, 8'h00);
    gap(0, 2, 0);
    gap(0, 2, 255);
    gap(1, 2, 4);
    for (int ch = 0; ch < 3; ch++)
      for (int c = 2; c < 8; c++)
        gap(ch, c, 1);
    wr(16'hff5b, 8'h01);
    wr(16'hff74, 8'h03);
    wr(16'hff5c, 8'h80);
    m = n_match2;
    ev_u.burst(2, 2);
    rd(16'hff75, 8'h02);
    ev_u.burst(3, 1);
    rd(16'hff75, 8'h01);
    `CHK(n_match2 - m, 1)
    wr(16'hff5c, 8'h00);
    wr(16'hff5b, 8'h00);
    wr(16'hff5c, 8'h80);
    ev_u.burst(2, 3);
    rd(16'hff75, 8'h02);
    wr(16'hff4f, 8'h04);
    ev_u.burst(3, 1);
    rd(16'hff75, 8'h02);
    GATING_TIMER_OUTPUT = 1'b1;
    ev_u.burst(1, 1);
    rd(16'hff75, 8'h03);
    wr(16'hff4f, 8'h00);
    wr(16'hff5c, 8'h00);
    wr(16'hff5b, 8'h01);
    wr(16'hff74, 8'h00);
    wr(16'hff76, 8'h80);
    wr(16'hff5c, 8'h80);
    ev_u.burst(5, 2);
    rd(16'hff77, 8'h04);
    rd(16'hff78, 8'h00);
    end_of_test();
  end
endmodule
